// >>> common/mce_pkg.sv
// Package: constants, encodings and carrier types of the machine-check code encoder
package mce_pkg;

  // ********************************************************************
  // Request field encodings
  // ********************************************************************
  typedef enum logic [3:0] {
    MCE_REQ_GENERIC   = 4'h0,
    MCE_REQ_RD        = 4'h1,
    MCE_REQ_WR        = 4'h2,
    MCE_REQ_DATA_LOAD = 4'h3,
    MCE_REQ_DATA_STOR = 4'h4,
    MCE_REQ_INSTR     = 4'h5,
    MCE_REQ_LOOKAHEAD = 4'h6,
    MCE_REQ_CASTOUT   = 4'h7,
    MCE_REQ_PROBE     = 4'h8
  } mce_req_t;

  // ********************************************************************
  // Sub-field encodings
  // ********************************************************************
  localparam logic [1:0] MCE_PART_LOCAL_ORIG = 2'h0;
  localparam logic [1:0] MCE_PART_LOCAL_ANS  = 2'h1;
  localparam logic [1:0] MCE_PART_THIRD      = 2'h2;
  localparam logic [1:0] MCE_PART_GENERIC    = 2'h3;
  localparam logic [1:0] MCE_MIO_MEM         = 2'h0;
  localparam logic [1:0] MCE_MIO_RSVD        = 2'h1;
  localparam logic [1:0] MCE_MIO_IO          = 2'h2;
  localparam logic [1:0] MCE_MIO_OTHER       = 2'h3;
  localparam logic [2:0] MCE_MTX_GENERIC     = 3'h0;
  localparam logic [2:0] MCE_MTX_SCRUB       = 3'h4;
  localparam logic [3:0] MCE_CHAN_NONE       = 4'hf;
  localparam logic [1:0] MCE_TT_INSTR        = 2'h0;
  localparam logic [1:0] MCE_TT_DATA         = 2'h1;
  localparam logic [1:0] MCE_TT_GENERIC      = 2'h2;
  localparam logic [1:0] MCE_LVL_GENERIC     = 2'h3;
  localparam logic [1:0] MCE_LVL_2           = 2'h2;
  localparam logic [2:0] MCE_ADDR_MODE_PHYS  = 3'h2;
  localparam logic [15:0] MCE_CODE_WRITEBACK = 16'h017a;
  localparam logic [7:0]  MCE_CODE_SCRUB_HI  = 8'h0c;

  // ********************************************************************
  // APB register map (byte addresses)
  // ********************************************************************
  localparam logic [7:0] MCE_OFS_STATUS = 8'h00;
  localparam logic [7:0] MCE_OFS_ADDR   = 8'h04;
  localparam logic [7:0] MCE_OFS_MISC   = 8'h08;
  localparam logic [7:0] MCE_OFS_GLOBAL = 8'h0c;
  localparam logic [7:0] MCE_OFS_CTRL   = 8'h10;

  // Status word bit positions
  localparam int MCE_ST_VALID = 31;
  localparam int MCE_ST_OVER  = 30;
  localparam int MCE_ST_UNC   = 29;
  localparam int MCE_ST_EN    = 28;
  localparam int MCE_ST_XINFO  = 27;
  localparam int MCE_ST_FADDR  = 26;
  localparam int MCE_ST_CTXBAD = 25;
  localparam int MCE_ST_SIG    = 24;
  localparam int MCE_ST_ACTREQ = 23;
  localparam int MCE_ST_FBIT  = 12;
  // Global word bit positions
  localparam int MCE_GL_RESTART = 0;
  localparam int MCE_GL_ERRPTR  = 1;
  localparam int MCE_GL_INPROG  = 2;
  // Control word bit positions
  localparam int MCE_CT_SHARED = 0;
  localparam int MCE_CT_UCR_EN = 1;
  localparam int MCE_CT_BANKEN = 2;

  // ********************************************************************
  // Error event classes
  // ********************************************************************
  typedef enum logic [2:0] {
    MCE_CLS_BUS       = 3'b000,
    MCE_CLS_CACHE     = 3'b001,
    MCE_CLS_MEMCTL    = 3'b010,
    MCE_CLS_SCRUB     = 3'b011,
    MCE_CLS_WRITEBACK = 3'b100
  } mce_cls_t;

  // Error event carrier
  typedef struct packed {
    mce_cls_t   cls;
    mce_req_t   request_field;
    logic       req_known;
    logic       instr_or_data_known;
    logic       is_store;
    logic [1:0] participation_field;
    logic       timed_out;
    logic [1:0] mem_io_field;
    logic [2:0] memory_txn_field;
    logic       chan_known;
    logic [3:0] channel_index;
    logic [1:0] txn_type_field;
    logic [1:0] level_field;
    logic [31:0] fault_address;
    logic [5:0] addr_lsb;
  } mce_event_t;

endpackage : mce_pkg

// >>> hw/mce_encoder.sv
// Machine-check compound error code encoder with one APB-visible error bank
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - Request field encodes nine action kinds, 0000 through 1000.
// - Unknown action gives generic fault; unknown instr/data gives generic read/store.
// - Castout and probe request codes appear only in cache codes.
// - Bus errors fill participation, time-out, memory-or-I/O, level and request.
// - Participation: 00 originated, 01 answered, 10 third party, 11 generic.
// - Time-out bit is 1 on timeout, else 0.
// - Memory-or-I/O: 00 memory, 10 I/O, 11 other; 01 reserved.
// - Memory transaction 000..100; values 101-111 reserved.
// - Channel 0000-1110 is a number, 1111 means unspecified.
// - Scrub and L3 writeback uncorrected errors are recoverable action-optional.
// - Scrub error logs as memory controller code 0xC0-0xCF.
// - L3 writeback error logs as cache code 0x17A.
// - Filtering bit 12 is 0 for both action-optional errors.
// - Action-optional log sets valid, uncorrected, enabled, info, address, signal; clears overflow, corrupt, action.
// - Action-optional errors publish failing address in address and misc registers.
// - Misc register holds physical address mode 010 and address LSB.
// - Uncorrected recoverable errors broadcast the machine-check signal to all processors.
// - Shared bank shows the error to sharers only.
// - Action-optional errors leave restart pointer valid 1 and error pointer 0.
// - Codes follow memory controller, cache and bus 16-bit forms.
// - Transaction type: 00 instruction, 01 data, 10 generic.
// - Level: 00, 01, 10 levels; 11 generic.
// - Detected error writes code into status bits 15:0 and sets valid.
module mce_encoder
  import mce_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        err_valid,
  input  wire mce_event_t  err_event,
  output logic             machine_check_signal,
  output logic             bank_visible
);

  // ********************************************************************
  // Code composition
  // ********************************************************************
  mce_req_t   req_sel;
  logic [1:0] mio_sel;
  logic [2:0] mtx_sel;
  logic [3:0] chan_sel;
  logic [15:0] code_next;
  logic        optional_evt;

  // Request field resolution, unknowns fall back to generic codes
  always_comb begin
    if (!err_event.req_known) begin
      req_sel = MCE_REQ_GENERIC;
    end else if (!err_event.instr_or_data_known) begin
      req_sel = err_event.is_store ? MCE_REQ_WR : MCE_REQ_RD;
    end else begin
      req_sel = err_event.request_field;
    end
    // Castout and probe are cache-only; elsewhere they fold to generic
    if (err_event.cls != MCE_CLS_CACHE &&
        (req_sel == MCE_REQ_CASTOUT || req_sel == MCE_REQ_PROBE)) begin
      req_sel = MCE_REQ_GENERIC;
    end
  end

  // Reserved sub-field values are replaced by the generic/other encodings
  always_comb begin
    mio_sel = (err_event.mem_io_field == MCE_MIO_RSVD) ? MCE_MIO_OTHER : err_event.mem_io_field;
    mtx_sel = (err_event.memory_txn_field > MCE_MTX_SCRUB) ? MCE_MTX_GENERIC
                                                            : err_event.memory_txn_field;
    chan_sel = err_event.chan_known ? err_event.channel_index : MCE_CHAN_NONE;
  end

  // Assemble the 16-bit compound code, F bit always normal
  always_comb begin
    optional_evt = (err_event.cls == MCE_CLS_SCRUB) || (err_event.cls == MCE_CLS_WRITEBACK);
    case (err_event.cls)
      MCE_CLS_BUS: begin
        code_next = {3'b000, 1'b0, 1'b1, err_event.participation_field, err_event.timed_out,
                     req_sel, mio_sel, err_event.level_field};
      end
      MCE_CLS_CACHE: begin
        code_next = {3'b000, 1'b0, 4'b0001, req_sel,
                     err_event.txn_type_field, err_event.level_field};
      end
      MCE_CLS_MEMCTL: begin
        code_next = {3'b000, 1'b0, 4'b0000, 1'b1, mtx_sel, chan_sel};
      end
      MCE_CLS_SCRUB: begin
        code_next = {4'h0, MCE_CODE_SCRUB_HI, chan_sel};
      end
      MCE_CLS_WRITEBACK: begin
        code_next = MCE_CODE_WRITEBACK;
      end
      default: begin
        code_next = {4'h0, MCE_CODE_SCRUB_HI, MCE_CHAN_NONE};
      end
    endcase
  end

  // ********************************************************************
  // Bank registers
  // ********************************************************************
  logic [31:0] bank_status_reg;
  logic [31:0] bank_fault_address_reg;
  logic [31:0] bank_extra_info_reg;
  logic [2:0]  global_check_status_reg;
  logic [2:0]  ctrl_reg;
  logic        log_evt;
  logic        apb_wr;
  logic        apb_rd;
  logic [31:0] status_next;

  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && penable && !pwrite;
  // An enabled bank takes every event and overwrites any earlier entry
  assign log_evt = err_valid && ctrl_reg[MCE_CT_BANKEN];

  // Status flag image for the incoming event
  always_comb begin
    status_next = 32'h0000_0000;
    status_next[15:0]           = code_next;
    status_next[MCE_ST_VALID]   = 1'b1;
    status_next[MCE_ST_OVER]    = bank_status_reg[MCE_ST_VALID] && !optional_evt;
    status_next[MCE_ST_UNC]     = optional_evt;
    status_next[MCE_ST_EN]      = 1'b1;
    status_next[MCE_ST_XINFO]   = optional_evt;
    status_next[MCE_ST_FADDR]   = optional_evt;
    status_next[MCE_ST_CTXBAD]  = 1'b0;
    status_next[MCE_ST_SIG]     = optional_evt;
    status_next[MCE_ST_ACTREQ]  = 1'b0;
    status_next[MCE_ST_FBIT]    = 1'b0;
  end

  // Status: logging wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_status_reg <= 32'h0000_0000;
    end else if (log_evt) begin
      bank_status_reg <= status_next;
    end else if (apb_wr && paddr == MCE_OFS_STATUS) begin
      bank_status_reg <= pwdata;
    end
  end

  // Address and misc capture for action-optional errors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_fault_address_reg <= 32'h0000_0000;
      bank_extra_info_reg    <= 32'h0000_0000;
    end else if (log_evt && optional_evt) begin
      bank_fault_address_reg <= err_event.fault_address;
      bank_extra_info_reg    <= {23'h000000, MCE_ADDR_MODE_PHYS, err_event.addr_lsb};
    end else if (apb_wr && paddr == MCE_OFS_ADDR) begin
      bank_fault_address_reg <= pwdata;
    end else if (apb_wr && paddr == MCE_OFS_MISC) begin
      bank_extra_info_reg <= pwdata;
    end
  end

  // Global status: restart ok, error pointer not exact, check in progress
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_check_status_reg <= 3'h0;
    end else if (err_valid && optional_evt) begin
      // Every processor sees this, reporting or not
      global_check_status_reg <= 3'b101;
    end else if (apb_wr && paddr == MCE_OFS_GLOBAL) begin
      global_check_status_reg <= pwdata[2:0];
    end
  end

  // Control: shared-bank, recoverable-support, bank enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 3'b111;
    end else if (apb_wr && paddr == MCE_OFS_CTRL) begin
      ctrl_reg <= pwdata[2:0];
    end
  end

  // Machine-check broadcast pulse, registered on the edge that takes err_valid, whether or not the bank logs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      machine_check_signal <= 1'b0;
    end else begin
      machine_check_signal <= err_valid && optional_evt && ctrl_reg[MCE_CT_UCR_EN];
    end
  end

  // Sharers see the bank; a private bank hides it from other processors
  assign bank_visible = bank_status_reg[MCE_ST_VALID] && ctrl_reg[MCE_CT_SHARED];

  // ********************************************************************
  // APB slave, zero wait states
  // ********************************************************************
  assign pready = 1'b1;
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    if (apb_rd || apb_wr) begin
      case (paddr)
        MCE_OFS_STATUS: prdata = bank_status_reg;
        MCE_OFS_ADDR:   prdata = bank_fault_address_reg;
        MCE_OFS_MISC:   prdata = bank_extra_info_reg;
        MCE_OFS_GLOBAL: prdata = {29'h0, global_check_status_reg};
        MCE_OFS_CTRL:   prdata = {29'h0, ctrl_reg};
        default:        pslverr = 1'b1;
      endcase
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  property p_scrub_code;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && err_event.cls == MCE_CLS_SCRUB) |=> (bank_status_reg[15:4] == 12'h00c);
  endproperty
  a_scrub_code: assert property (p_scrub_code) else $error("scrub code wrong");

  property p_wb_code;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && err_event.cls == MCE_CLS_WRITEBACK) |=> (bank_status_reg[15:0] == 16'h017a);
  endproperty
  a_wb_code: assert property (p_wb_code) else $error("writeback code wrong");

  property p_flags;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && optional_evt) |=> (bank_status_reg[31:23] == 9'b101111010 && !bank_status_reg[12]);
  endproperty
  a_flags: assert property (p_flags) else $error("optional status flags wrong");

  property p_valid;
    @(posedge pclk) disable iff (!presetn)
      log_evt |=> bank_status_reg[MCE_ST_VALID];
  endproperty
  a_valid: assert property (p_valid) else $error("valid not set");

  property p_mce;
    @(posedge pclk) disable iff (!presetn)
      (err_valid && optional_evt && ctrl_reg[MCE_CT_UCR_EN]) |=> machine_check_signal;
  endproperty
  a_mce: assert property (p_mce) else $error("broadcast missing");

  // Back-to-back events keep the pulse high; otherwise it lasts one cycle
  property p_mce_quiet;
    @(posedge pclk) disable iff (!presetn)
      !(err_valid && optional_evt && ctrl_reg[MCE_CT_UCR_EN]) |=> !machine_check_signal;
  endproperty
  a_mce_quiet: assert property (p_mce_quiet) else $error("stray broadcast");

  property p_global;
    @(posedge pclk) disable iff (!presetn)
      (err_valid && optional_evt) |=> (global_check_status_reg[1:0] == 2'b01);
  endproperty
  a_global: assert property (p_global) else $error("pointer flags wrong");

  property p_no_rsvd_mio;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && err_event.cls == MCE_CLS_BUS) |=> (bank_status_reg[3:2] != 2'b01);
  endproperty
  a_no_rsvd_mio: assert property (p_no_rsvd_mio) else $error("reserved io field");

  property p_no_rsvd_mtx;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && err_event.cls == MCE_CLS_MEMCTL) |=> (bank_status_reg[6:4] <= 3'b100);
  endproperty
  a_no_rsvd_mtx: assert property (p_no_rsvd_mtx) else $error("reserved txn field");

  property p_misc_mode;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && optional_evt) |=> (bank_extra_info_reg[8:6] == 3'b010);
  endproperty
  a_misc_mode: assert property (p_misc_mode) else $error("misc mode wrong");

  // Field placement per code form, checked against the event that was logged
  property p_form_bus;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && err_event.cls == MCE_CLS_BUS) |=> (bank_status_reg[15:11] == 5'b00001);
  endproperty
  a_form_bus: assert property (p_form_bus) else $error("bus form wrong");

  property p_form_cache;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && err_event.cls == MCE_CLS_CACHE) |=> (bank_status_reg[15:8] == 8'h01);
  endproperty
  a_form_cache: assert property (p_form_cache) else $error("cache form wrong");

  property p_form_mem;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && err_event.cls == MCE_CLS_MEMCTL) |=> (bank_status_reg[15:7] == 9'h001);
  endproperty
  a_form_mem: assert property (p_form_mem) else $error("memory form wrong");

  property p_fbit;
    @(posedge pclk) disable iff (!presetn)
      log_evt |=> !bank_status_reg[MCE_ST_FBIT];
  endproperty
  a_fbit: assert property (p_fbit) else $error("filter bit set");

  property p_no_line_castout;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && err_event.cls == MCE_CLS_BUS) |=>
        (bank_status_reg[7:4] != 4'h7 && bank_status_reg[7:4] != 4'h8);
  endproperty
  a_no_line_castout: assert property (p_no_line_castout) else $error("cache-only request on bus");

  property p_req_unknown;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && !err_event.req_known && (err_event.cls == MCE_CLS_BUS || err_event.cls == MCE_CLS_CACHE))
        |=> (bank_status_reg[7:4] == 4'h0);
  endproperty
  a_req_unknown: assert property (p_req_unknown) else $error("unknown request not generic");

  property p_req_guess;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && err_event.cls == MCE_CLS_CACHE && err_event.req_known && !err_event.instr_or_data_known)
        |=> (bank_status_reg[7:4] == ($past(err_event.is_store) ? 4'h2 : 4'h1));
  endproperty
  a_req_guess: assert property (p_req_guess) else $error("generic read or write wrong");

  property p_chan_none;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && !err_event.chan_known && (err_event.cls == MCE_CLS_SCRUB || err_event.cls == MCE_CLS_MEMCTL))
        |=> (bank_status_reg[3:0] == 4'hf);
  endproperty
  a_chan_none: assert property (p_chan_none) else $error("unspecified channel wrong");

  property p_chan_mem;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && err_event.cls == MCE_CLS_MEMCTL && err_event.chan_known)
        |=> (bank_status_reg[3:0] == $past(err_event.channel_index));
  endproperty
  a_chan_mem: assert property (p_chan_mem) else $error("channel number wrong");

  property p_timeout;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && err_event.cls == MCE_CLS_BUS) |=> (bank_status_reg[8] == $past(err_event.timed_out));
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out bit wrong");

  property p_part;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && err_event.cls == MCE_CLS_BUS)
        |=> (bank_status_reg[10:9] == $past(err_event.participation_field));
  endproperty
  a_part: assert property (p_part) else $error("participation wrong");

  property p_mio;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && err_event.cls == MCE_CLS_BUS && err_event.mem_io_field != MCE_MIO_RSVD)
        |=> (bank_status_reg[3:2] == $past(err_event.mem_io_field));
  endproperty
  a_mio: assert property (p_mio) else $error("memory-or-io wrong");

  property p_txn;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && err_event.cls == MCE_CLS_CACHE) |=> (bank_status_reg[3:2] == $past(err_event.txn_type_field));
  endproperty
  a_txn: assert property (p_txn) else $error("transaction type wrong");

  property p_level;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && (err_event.cls == MCE_CLS_CACHE || err_event.cls == MCE_CLS_BUS))
        |=> (bank_status_reg[1:0] == $past(err_event.level_field));
  endproperty
  a_level: assert property (p_level) else $error("level wrong");

  // Address capture must track the event, not a stale software value
  property p_addr_cap;
    @(posedge pclk) disable iff (!presetn)
      (log_evt && optional_evt) |=> (bank_fault_address_reg == $past(err_event.fault_address));
  endproperty
  a_addr_cap: assert property (p_addr_cap) else $error("fault address not captured");

endmodule : mce_encoder

// >>> dv/mce_encoder_tb_top.sv
// Self-checking testbench of the machine-check code encoder
`timescale 1ns/1ps
module mce_encoder_tb_top
  import mce_pkg::*;
;
  logic        pclk      = 1'b0;
  logic        presetn   = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        err_valid = 1'b0;
  mce_event_t  err_event = '0;
  logic        machine_check_signal;
  logic        bank_visible;
  int          errors    = 0;
  int          cmp_count = 0;
  int          cycles    = 0;
  logic [31:0] rd;
  logic        se;

  mce_encoder u_mce_encoder (
    .pclk                 (pclk),
    .presetn              (presetn),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .err_valid            (err_valid),
    .err_event            (err_event),
    .machine_check_signal (machine_check_signal),
    .bank_visible         (bank_visible)
  );

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      $display("unexpected at %0t: run did not finish", $time);
      conclude();
    end
  end

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, then an idle cycle so back-to-back calls never double-drive psel
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The wait ends at the first edge with pready high; the bench hang guard stops a stuck transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // One-cycle event pulse; the broadcast pulse stands exactly one cycle after the logging edge
  task automatic fire(input mce_event_t ev, input logic exp_mce);
    err_valid <= 1'b1;
    err_event <= ev;
    @(posedge pclk);
    err_valid <= 1'b0;
    #1;
    chk({31'h0, machine_check_signal}, {31'h0, exp_mce});
    @(posedge pclk);
    #1;
    chk({31'h0, machine_check_signal}, 32'h0);
    @(posedge pclk);
  endtask : fire

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_reset();
    chk({31'h0, pready}, 32'h1);
    rdchk(MCE_OFS_STATUS, 32'h0);
    rdchk(MCE_OFS_ADDR, 32'h0);
    rdchk(MCE_OFS_MISC, 32'h0);
    rdchk(MCE_OFS_GLOBAL, 32'h0);
    rdchk(MCE_OFS_CTRL, 32'h7);
    apb(1'b1, 8'h14, 32'hffff_ffff);
    chk({31'h0, se}, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, se}, 32'h1);
    chk(rd, 32'h0);
  endtask : t_reset

  // Scrub with channel 3, scrub with unknown channel, writeback with misleading sub-fields
  task automatic t_opt();
    mce_event_t  ev;
    logic [15:0] code;
    for (int i = 0; i < 3; i++) begin
      ev = '0;
      ev.cls = (i == 2) ? MCE_CLS_WRITEBACK : MCE_CLS_SCRUB;
      ev.request_field = MCE_REQ_RD;
      ev.memory_txn_field = 3'h1;
      ev.chan_known = (i == 0);
      ev.channel_index = 4'h3;
      ev.fault_address = 32'h1234_5000 + 32'(i);
      ev.addr_lsb = 6'(12 + i);
      code = (i == 2) ? 16'h017a : ((i == 0) ? 16'h00c3 : 16'h00cf);
      fire(ev, 1'b1);
      rdchk(MCE_OFS_STATUS, 32'hbd00_0000 | {16'h0, code});
      rdchk(MCE_OFS_ADDR, ev.fault_address);
      rdchk(MCE_OFS_MISC, {23'h0, 3'h2, ev.addr_lsb});
      apb(1'b0, MCE_OFS_GLOBAL, 32'h0);
      chk({30'h0, rd[1:0]}, 32'h1);
    end
  endtask : t_opt

  // Every participation value, reserved memory-or-I/O, cache-only requests on a bus error
  task automatic t_bus();
    mce_event_t  ev;
    logic [15:0] code;
    logic [3:0]  req;
    logic [1:0]  mio;
    for (int p = 0; p < 4; p++) begin
      ev = '0;
      ev.cls = MCE_CLS_BUS;
      ev.req_known = 1'b1;
      ev.instr_or_data_known = 1'b1;
      ev.request_field = (p == 1) ? MCE_REQ_CASTOUT : ((p == 3) ? MCE_REQ_PROBE : MCE_REQ_DATA_STOR);
      ev.participation_field = 2'(p);
      ev.timed_out = p[0];
      ev.mem_io_field = 2'(p);
      ev.level_field = 2'(3 - p);
      req = p[0] ? 4'h0 : 4'h4;
      mio = (p == 1) ? 2'h3 : 2'(p);
      code = {4'h0, 1'b1, 2'(p), p[0], req, mio, 2'(3 - p)};
      fire(ev, 1'b0);
      apb(1'b0, MCE_OFS_STATUS, 32'h0);
      chk(rd & 32'hf000_ffff, {4'hd, 12'h0, code});
    end
  endtask : t_bus

  // All nine request codes, then unknown action and unknown instruction/data
  task automatic t_cache();
    mce_event_t  ev;
    logic [3:0]  req;
    for (int r = 0; r < 12; r++) begin
      ev = '0;
      ev.cls = MCE_CLS_CACHE;
      ev.request_field = mce_req_t'((r > 8) ? 3 : r);
      ev.req_known = (r != 9);
      ev.instr_or_data_known = (r < 10);
      ev.is_store = (r == 10);
      ev.txn_type_field = 2'(r % 3);
      ev.level_field = 2'(r);
      req = (r < 9) ? 4'(r) : ((r == 9) ? 4'h0 : ((r == 10) ? 4'h2 : 4'h1));
      fire(ev, 1'b0);
      apb(1'b0, MCE_OFS_STATUS, 32'h0);
      chk(rd & 32'ha000_ffff, {4'h8, 12'h0, 8'h01, req, 2'(r % 3), 2'(r)});
    end
  endtask : t_cache

  // Memory transaction codes except 100, including reserved ones, channel up to 1110
  task automatic t_mem();
    mce_event_t  ev;
    logic [2:0]  mtx;
    for (int m = 0; m < 8; m++) begin
      if (m == 4) continue;
      ev = '0;
      ev.cls = MCE_CLS_MEMCTL;
      ev.memory_txn_field = 3'(m);
      ev.chan_known = 1'b1;
      ev.channel_index = 4'(2 * m);
      mtx = (m > 4) ? 3'h0 : 3'(m);
      fire(ev, 1'b0);
      apb(1'b0, MCE_OFS_STATUS, 32'h0);
      chk(rd & 32'ha000_ffff, {4'h8, 12'h0, 8'h00, 1'b1, mtx, 4'(2 * m)});
    end
  endtask : t_mem

  // Bank enable, broadcast enable and sharing through the control word
  task automatic t_ctrl();
    mce_event_t  ev;
    logic [31:0] old;
    ev = '0;
    ev.cls = MCE_CLS_SCRUB;
    ev.chan_known = 1'b1;
    ev.channel_index = 4'h1;
    apb(1'b1, MCE_OFS_CTRL, 32'h3);
    apb(1'b0, MCE_OFS_STATUS, 32'h0);
    old = rd;
    fire(ev, 1'b1);
    rdchk(MCE_OFS_STATUS, old);
    chk({31'h0, bank_visible}, 32'h1);
    apb(1'b1, MCE_OFS_CTRL, 32'h4);
    chk({31'h0, bank_visible}, 32'h0);
    fire(ev, 1'b0);
    rdchk(MCE_OFS_STATUS, 32'hbd00_00c1);
    apb(1'b1, MCE_OFS_CTRL, 32'h7);
    chk({31'h0, bank_visible}, 32'h1);
    apb(1'b1, MCE_OFS_STATUS, 32'h0);
    chk({31'h0, bank_visible}, 32'h0);
    rdchk(MCE_OFS_STATUS, 32'h0);
  endtask : t_ctrl

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_opt();
    t_bus();
    t_cache();
    t_mem();
    t_ctrl();
    conclude();
  end
endmodule : mce_encoder_tb_top
